// ---- common/pmta_defines.vh ----
`ifndef PMTA_DEFINES_VH
`define PMTA_DEFINES_VH
`define PMTA_ROW_WORDS 32
`define PMTA_ROW_AW 5
`define PMTA_KEY1 8'h55
`define PMTA_KEY2 8'hAA
`define PMTA_CFG_BIT 7
`define PMTA_VIS_BIT 2
`define PMTA_OP_ROW1 6'h18
`define PMTA_OP_ROW2 6'h19
`define PMTA_OP_ROW4 6'h1A
`define PMTA_CTL_WR 15
`define PMTA_CTL_WREN 14
`define PMTA_CTL_ERASE 6
`define PMTA_TBLWR_CYC 2
`define PMTA_FLASH_TIME_NS 2000
`define PMTA_CLK_NS 4
`define PMTA_FLASH_CYC (`PMTA_FLASH_TIME_NS / `PMTA_CLK_NS)
`endif

// ---- logic/pmta_access_unit.v ----
`timescale 1ns/100ps
`default_nettype none
`include "pmta_defines.vh"
module pmta_access_unit #(
   parameter FLASH_CYC = `PMTA_FLASH_CYC,
   parameter CFG_IMPL_BASE = 16'h0000,
   parameter CFG_IMPL_SIZE = 16'h0004
) (
   input wire mclk,
   input wire reset,
   // Table port
   input wire tblReq,
   input wire tblWrite,
   input wire tblHigh,
   input wire tblByte,
   input wire [7:0] tablePageReg,
   input wire [15:0] tblEa,
   input wire [15:0] tblWrData,
   // Data-space port
   input wire dataReq,
   input wire [15:0] dataEa,
   input wire [15:0] coreControlReg,
   input wire [7:0] windowPageReg,
   input wire moveInstr,
   input wire inRepeat,
   input wire repFirst,
   input wire repLast,
   input wire repIrqEdge,
   // Flash control
   input wire keyWrite,
   input wire [7:0] keyData,
   input wire ctlWrite,
   input wire [15:0] ctlData,
   // Flash array side
   input wire [23:0] arrayRdData,
   input wire arrayBusy,
   output reg arrayRdEn_r,
   output reg [23:0] arrayAddr_r,
   output reg arrayProg_r,
   output reg arrayErase_r,
   output reg [23:0] arrayWrData_r,
   // Answers
   output reg tblDone_r,
   output reg [15:0] tblRdData_r,
   output reg tblRefused_r,
   output reg windowHit_r,
   output reg [1:0] extraCycles_r,
   output reg [15:0] windowData_r,
   output reg [15:0] flashControlReg_r,
   output reg stall_r
);
   localparam ST_IDLE = 3'h0;
   localparam ST_TRD = 3'h1;
   localparam ST_TWR = 3'h2;
   localparam ST_FLASH = 3'h3;
   localparam ST_WIN = 3'h4;

   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg keyStage_r;
   reg unlocked_r;
   reg [31:0] timer_r;
   reg [4:0] rowPtr_r;
   reg [23:0] opAddr_r;
   reg opHigh_r;
   reg opByte_r;
   reg opBs_r;
   wire [15:0] rdFmt;

   // -----------------------------------------------------------------
   // Address formation
   // -----------------------------------------------------------------
   wire [23:0] tblAddr = {tablePageReg, tblEa};
   wire cfgSpace = tablePageReg[`PMTA_CFG_BIT];
   wire cfgImpl = (tblEa >= CFG_IMPL_BASE) && (tblEa < CFG_IMPL_BASE + CFG_IMPL_SIZE);
   // Word address bit 0 is byte select; the program word is addressed by two
   wire [23:0] tblWordAddr = {tblAddr[23:1], 1'b0};
   wire tableBusy = (state_r == ST_TRD) || (state_r == ST_TWR);
   wire winReq = dataReq && dataEa[15] && coreControlReg[`PMTA_VIS_BIT] && !tableBusy;
   wire [23:0] winAddr = {1'b0, windowPageReg, dataEa[14:0]};
   wire [5:0] flashOp = flashControlReg_r[5:0];
   wire opValid = (flashOp == `PMTA_OP_ROW1) || (flashOp == `PMTA_OP_ROW2) || (flashOp == `PMTA_OP_ROW4);
   wire [23:0] latchWord;
   wire latchLoaded;
   // Configuration-space writes never reach a latch
   wire latchWr = (state_r == ST_TWR) && (timer_r == 32'h0) && !opAddr_r[23];

   pmta_read_format uFmt (
      .progWord(arrayRdData),
      .highSel(opHigh_r),
      .byteMode(opByte_r),
      .byteSel(opBs_r),
      .dataOut(rdFmt)
   );

   // Writes go to latches only, never to the array directly
   pmta_latch_bank #(.WORDS(`PMTA_ROW_WORDS), .AW(`PMTA_ROW_AW)) uLatch (
      .mclk(mclk),
      .reset(reset),
      .clearAll(state_r == ST_FLASH && state_nxt == ST_IDLE),
      .wrEn(latchWr),
      .wrIdx(opAddr_r[5:1]),
      .wrHigh(opHigh_r),
      .byteMode(opByte_r),
      .byteSel(opBs_r),
      .wrData(tblWrData),
      .rdIdx(rowPtr_r),
      .rdWord(latchWord),
      .rdLoaded(latchLoaded)
   );

   // Row count per erase size, erase base aligned on block size
   function [23:0] alignBase;
      input [23:0] a;
      input [1:0] sz;
      reg [23:0] rowNum;
      reg [23:0] unitRows;
      begin
         rowNum = a / 24'd64;
         unitRows = (sz == 2'b10) ? 24'd4 : ((sz == 2'b01) ? 24'd2 : 24'd1);
         alignBase = (rowNum - (rowNum % unitRows)) * 24'd64;
      end
   endfunction

   // -----------------------------------------------------------------
   // State machine
   // -----------------------------------------------------------------
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (flashControlReg_r[`PMTA_CTL_WR])
               state_nxt = ST_FLASH;
            else if (tblReq && tblWrite)
               state_nxt = ST_TWR;
            else if (tblReq)
               state_nxt = ST_TRD;
            else if (winReq)
               state_nxt = ST_WIN;
         end
         ST_TRD: state_nxt = ST_IDLE;
         ST_TWR: if (timer_r == 32'h0) state_nxt = ST_IDLE;
         ST_WIN: state_nxt = ST_IDLE;
         ST_FLASH: if (timer_r == 32'h0 && !arrayBusy) state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_r <= ST_IDLE;
         keyStage_r <= 1'b0;
         unlocked_r <= 1'b0;
         timer_r <= 32'h0;
         rowPtr_r <= 5'h00;
         opAddr_r <= 24'h000000;
         opHigh_r <= 1'b0;
         opByte_r <= 1'b0;
         opBs_r <= 1'b0;
         arrayRdEn_r <= 1'b0;
         arrayAddr_r <= 24'h000000;
         arrayProg_r <= 1'b0;
         arrayErase_r <= 1'b0;
         arrayWrData_r <= 24'h000000;
         tblDone_r <= 1'b0;
         tblRdData_r <= 16'h0000;
         tblRefused_r <= 1'b0;
         windowHit_r <= 1'b0;
         extraCycles_r <= 2'h0;
         windowData_r <= 16'h0000;
         flashControlReg_r <= 16'h0000;
         stall_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         tblDone_r <= 1'b0;
         tblRefused_r <= 1'b0;
         windowHit_r <= 1'b0;
         arrayRdEn_r <= 1'b0;
         arrayProg_r <= 1'b0;
         arrayErase_r <= 1'b0;
         // Unlock keys may be spaced by idle cycles; a control, table or data request between them cancels the first
         if (keyWrite) begin
            keyStage_r <= (keyData == `PMTA_KEY1);
            unlocked_r <= keyStage_r && (keyData == `PMTA_KEY2);
         end else if (ctlWrite || tblReq || dataReq) begin
            keyStage_r <= 1'b0;
         end
         if (ctlWrite && state_r != ST_FLASH) begin
            flashControlReg_r[14:0] <= {ctlData[14:12], 5'h00, ctlData[6:0]};
            // Write start only honoured after unlock and with enable
            if (ctlData[`PMTA_CTL_WR] && unlocked_r && ctlData[`PMTA_CTL_WREN]) begin
               flashControlReg_r[`PMTA_CTL_WR] <= 1'b1;
               unlocked_r <= 1'b0;
            end
         end
         case (state_r)
            ST_IDLE: begin
               if (flashControlReg_r[`PMTA_CTL_WR]) begin
                  stall_r <= 1'b1;
                  timer_r <= FLASH_CYC - 1;
                  rowPtr_r <= 5'h00;
               end else if (tblReq) begin
                  opAddr_r <= tblWordAddr;
                  opHigh_r <= tblHigh;
                  opByte_r <= tblByte;
                  opBs_r <= tblEa[0];
                  if (tblWrite) begin
                     timer_r <= `PMTA_TBLWR_CYC - 1;
                  end else if (!cfgSpace || cfgImpl) begin
                     arrayRdEn_r <= 1'b1;
                     arrayAddr_r <= tblWordAddr;
                  end
               end else if (winReq) begin
                  arrayRdEn_r <= 1'b1;
                  arrayAddr_r <= winAddr;
                  if (!inRepeat)
                     extraCycles_r <= moveInstr ? 2'h1 : 2'h2;
                  else if (repFirst || repLast || repIrqEdge)
                     extraCycles_r <= 2'h2;
                  else
                     extraCycles_r <= 2'h1;
               end
            end
            ST_TRD: begin
               tblDone_r <= 1'b1;
               if (opAddr_r[23] && !(opAddr_r[15:0] >= CFG_IMPL_BASE && opAddr_r[15:0] < CFG_IMPL_BASE + CFG_IMPL_SIZE)) begin
                  tblRdData_r <= 16'h0000;
                  tblRefused_r <= 1'b1;
               end else
                  tblRdData_r <= rdFmt;
            end
            ST_TWR: begin
               if (timer_r != 32'h0)
                  timer_r <= timer_r - 32'h1;
               else begin
                  tblDone_r <= 1'b1;
                  tblRefused_r <= opAddr_r[23];
               end
            end
            ST_WIN: begin
               windowHit_r <= 1'b1;
               windowData_r <= arrayRdData[15:0];
            end
            ST_FLASH: begin
               if (timer_r != 32'h0)
                  timer_r <= timer_r - 32'h1;
               if (flashControlReg_r[`PMTA_CTL_ERASE] && timer_r == FLASH_CYC - 1) begin
                  if (opValid) begin
                     arrayErase_r <= 1'b1;
                     arrayAddr_r <= alignBase(opAddr_r, flashOp[1:0]);
                  end
               end else if (!flashControlReg_r[`PMTA_CTL_ERASE] && flashOp == `PMTA_OP_ROW1) begin
                  // Unloaded latches are skipped, single words allowed
                  // One pass over the row only, else the last latch repeats
                  if (latchLoaded && timer_r > FLASH_CYC - 33) begin
                     arrayProg_r <= 1'b1;
                     arrayAddr_r <= {alignBase(opAddr_r, 2'b00) + {18'h0, rowPtr_r, 1'b0}};
                     arrayWrData_r <= latchWord;
                  end
                  if (rowPtr_r != 5'h1F)
                     rowPtr_r <= rowPtr_r + 5'h01;
               end
               if (state_nxt == ST_IDLE) begin
                  flashControlReg_r[`PMTA_CTL_WR] <= 1'b0;
                  stall_r <= 1'b0;
               end
            end
            default: ;
         endcase
      end
   end
endmodule // pmta_access_unit
`default_nettype wire

// ---- logic/pmta_latch_bank.v ----
`timescale 1ns/100ps
`default_nettype none
`include "pmta_defines.vh"
module pmta_latch_bank #(
   parameter WORDS = `PMTA_ROW_WORDS,
   parameter AW = `PMTA_ROW_AW
) (
   input wire mclk,
   input wire reset,
   input wire clearAll,
   input wire wrEn,
   input wire [AW-1:0] wrIdx,
   input wire wrHigh,
   input wire byteMode,
   input wire byteSel,
   input wire [15:0] wrData,
   input wire [AW-1:0] rdIdx,
   output wire [23:0] rdWord,
   output wire rdLoaded
);
   wire [23:0] words [0:WORDS-1];
   wire [WORDS-1:0] loaded;
   genvar g;
   generate
      for (g = 0; g < WORDS; g = g + 1) begin : gLatch
         reg [23:0] word_r;
         reg loaded_r;
         localparam [AW-1:0] IDX = g;
         wire hit = wrEn && (wrIdx == IDX);
         always @(posedge mclk or posedge reset) begin
            if (reset) begin
               word_r <= 24'hFFFFFF;
               loaded_r <= 1'b0;
            end else if (clearAll) begin
               word_r <= 24'hFFFFFF;
               loaded_r <= 1'b0;
            end else if (hit) begin
               // Any order, last write wins
               loaded_r <= 1'b1;
               if (wrHigh) begin
                  if (!(byteMode && byteSel))
                     word_r[23:16] <= wrData[7:0];
               end else if (!byteMode)
                  word_r[15:0] <= wrData;
               else if (byteSel)
                  word_r[15:8] <= wrData[7:0];
               else
                  word_r[7:0] <= wrData[7:0];
            end
         end
         assign words[g] = word_r;
         assign loaded[g] = loaded_r;
      end
   endgenerate
   assign rdWord = words[rdIdx];
   assign rdLoaded = loaded[rdIdx];
endmodule // pmta_latch_bank
`default_nettype wire

// ---- logic/pmta_read_format.v ----
`timescale 1ns/100ps
`default_nettype none
module pmta_read_format (
   input wire [23:0] progWord,
   input wire highSel,
   input wire byteMode,
   input wire byteSel,
   output reg [15:0] dataOut
);
   always @* begin
      if (!highSel) begin
         if (!byteMode)
            dataOut = progWord[15:0];
         else if (byteSel)
            dataOut = {8'h00, progWord[15:8]};
         else
            dataOut = {8'h00, progWord[7:0]};
      end else begin
         if (byteMode && byteSel)
            dataOut = 16'h0000;
         else
            dataOut = {8'h00, progWord[23:16]};
      end
   end
endmodule // pmta_read_format
`default_nettype wire

// ---- verif/pmta_access_unit_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module pmta_access_unit_properties #(
   parameter FLASH_CYC = 40
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic tblReq,
   input wire logic tblWrite,
   input wire logic tblHigh,
   input wire logic tblByte,
   input wire logic [7:0] tablePageReg,
   input wire logic [15:0] tblEa,
   input wire logic dataReq,
   input wire logic [15:0] dataEa,
   input wire logic [15:0] coreControlReg,
   input wire logic [7:0] windowPageReg,
   input wire logic moveInstr,
   input wire logic inRepeat,
   input wire logic repFirst,
   input wire logic repLast,
   input wire logic repIrqEdge,
   input wire logic arrayRdEn_r,
   input wire logic [23:0] arrayAddr_r,
   input wire logic arrayErase_r,
   input wire logic tblDone_r,
   input wire logic [15:0] tblRdData_r,
   input wire logic windowHit_r,
   input wire logic [1:0] extraCycles_r,
   input wire logic [15:0] flashControlReg_r,
   input wire logic stall_r
);
   localparam int WMAX = 1000;
   wire idle = !stall_r && !flashControlReg_r[15];
   wire winOk = dataReq && dataEa[15] && coreControlReg[2] && !tblReq && idle;
   wire rdOk = tblReq && !tblWrite && idle;
   wire [1:0] xc = !inRepeat ? (moveInstr ? 2'h1 : 2'h2) : ((repFirst || repLast || repIrqEdge) ? 2'h2 : 2'h1);
   wire [1:0] op = flashControlReg_r[1:0];
   wire [7:0] amask = (op == 2'h0) ? 8'h3F : ((op == 2'h1) ? 8'h7F : 8'hFF);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_rdAnswer; ##1 arrayRdEn_r ##1 tblDone_r; endsequence
   sequence s_flashRun; stall_r ##[1:WMAX] (!flashControlReg_r[15] && !stall_r); endsequence
   property p_rdAddr;
      rdOk && !tablePageReg[7] |=> arrayAddr_r[23:1] == {$past(tablePageReg), $past(tblEa[15:1])};
   endproperty
   a_rdAddr: assert property (p_rdAddr) else $error("table address wrong");
   property p_hiPhantom; rdOk && tblHigh && !tblByte |-> s_rdAnswer ##0 tblRdData_r[15:8] == 8'h00; endproperty
   a_hiPhantom: assert property (p_hiPhantom) else $error("phantom byte set");
   property p_wrTime; tblReq && tblWrite && idle |-> ##1 !tblDone_r ##[1:2] tblDone_r; endproperty
   a_wrTime: assert property (p_wrTime) else $error("latch write timing");
   property p_winAddr;
      winOk |=> arrayRdEn_r && !arrayAddr_r[23] && arrayAddr_r[22:1] == {$past(windowPageReg), $past(dataEa[14:1])};
   endproperty
   a_winAddr: assert property (p_winAddr) else $error("window address wrong");
   property p_winXc; winOk |=> extraCycles_r == $past(xc); endproperty
   a_winXc: assert property (p_winXc) else $error("extra cycles wrong");
   property p_winCause; windowHit_r |-> $past(winOk, 2); endproperty
   a_winCause: assert property (p_winCause) else $error("window hit without cause");
   property p_start; $rose(flashControlReg_r[15]) |=> s_flashRun; endproperty
   a_start: assert property (p_start) else $error("flash run wrong");
   property p_erase; arrayErase_r |-> (arrayAddr_r[7:0] & amask) == 8'h00 ##1 !arrayErase_r; endproperty
   a_erase: assert property (p_erase) else $error("erase base misaligned");
endmodule // pmta_access_unit_properties
bind pmta_access_unit pmta_access_unit_properties #(.FLASH_CYC(FLASH_CYC)) i_pmta_access_unit_properties (.*);
`default_nettype wire

// ---- verif/pmta_flash_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module pmta_flash_model (
   input wire logic mclk,
   input wire logic arrayRdEn_r,
   input wire logic [23:0] arrayAddr_r,
   input wire logic arrayProg_r,
   input wire logic arrayErase_r,
   input wire logic [23:0] arrayWrData_r,
   output logic [23:0] arrayRdData,
   output logic arrayBusy
);
   logic [23:0] mem [256];
   logic hold_r = 1'b0;
   int busyCnt = 0;
   wire [7:0] idx = arrayAddr_r[8:1];
   initial begin
      for (int i = 0; i < 256; i++)
         mem[i] = 24'h5AC396 ^ {3{i[7:0]}};
   end
   // Stale word shown inverted so a late sample fails
   assign arrayRdData = (arrayRdEn_r || hold_r) ? mem[idx] : ~mem[idx];
   assign arrayBusy = busyCnt != 0;
   always @(posedge mclk) begin
      hold_r <= arrayRdEn_r;
      busyCnt <= (busyCnt > 0) ? busyCnt - 1 : 0;
      if (arrayProg_r)
         mem[idx] <= arrayWrData_r;
      if (arrayErase_r) begin
         busyCnt <= 8;
         for (int i = 0; i < 32; i++)
            mem[{idx[7:5], 5'h00} + i] <= 24'hFFFFFF;
      end
   end
endmodule // pmta_flash_model
`default_nettype wire

// ---- verif/tb_pmta_access_unit.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_pmta_access_unit;
   typedef struct {logic hi; logic by; logic [15:0] ea; logic [15:0] ex;} pmta_row_t;
   logic mclk, reset, tblReq, tblWrite, tblHigh, tblByte, dataReq, moveInstr, inRepeat;
   logic repFirst, repLast, repIrqEdge, keyWrite, ctlWrite, refd, started;
   logic [7:0] tablePageReg, windowPageReg, keyData;
   logic [15:0] tblEa, tblWrData, dataEa, coreControlReg, ctlData, rd;
   logic [23:0] eraseAddr;
   logic [1:0] xcv;
   wire arrayBusy, arrayRdEn_r, arrayProg_r, arrayErase_r, tblDone_r, tblRefused_r, windowHit_r, stall_r;
   wire [1:0] extraCycles_r;
   wire [15:0] tblRdData_r, windowData_r, flashControlReg_r;
   wire [23:0] arrayRdData, arrayAddr_r, arrayWrData_r;
   int fails, total_checks, progs, erases, hits, n0;
   pmta_row_t rows [6] = '{'{0, 0, 16'h0010, 16'hCB9E}, '{0, 1, 16'h0010, 16'h009E},
      '{0, 1, 16'h0011, 16'h00CB}, '{1, 0, 16'h0010, 16'h0052},
      '{1, 1, 16'h0010, 16'h0052}, '{1, 1, 16'h0011, 16'h0000}};
   // Mode bits beside expected extra cycles
   logic [6:0] xrows [6] = '{7'h41, 7'h02, 7'h21, 7'h32, 7'h2A, 7'h26};
   pmta_access_unit #(.FLASH_CYC(40)) i_pmta_access_unit (.*);
   pmta_flash_model i_pmta_flash_model (.*);
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      progs += (arrayProg_r === 1'b1);
      hits += (windowHit_r === 1'b1);
      if (arrayErase_r === 1'b1)
         eraseAddr = arrayAddr_r;
      erases += (arrayErase_r === 1'b1);
   end
   // ----
   // Tasks
   // ----
   task chk(input string nm, input logic [23:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task tbl(input logic w, hi, by, input logic [7:0] pg, input logic [15:0] ea, wd);
      {tblWrite, tblHigh, tblByte, tablePageReg, tblEa, tblWrData, tblReq} = {w, hi, by, pg, ea, wd, 1'b1};
      tick(1);
      {tblReq, dataReq} = 2'b00;
      for (int k = 0; k < 9 && tblDone_r !== 1'b1; k++)
         tick(1);
      chk("table done", tblDone_r, 1);
      {rd, refd} = {tblRdData_r, tblRefused_r};
      tick(1);
   endtask
   task win(input logic [15:0] ea, cc, input logic [4:0] fl);
      {dataEa, coreControlReg, moveInstr, inRepeat, repFirst, repLast, repIrqEdge} = {ea, cc, fl};
      n0 = hits;
      dataReq = 1'b1;
      tick(1);
      dataReq = 1'b0;
      xcv = extraCycles_r;
      tick(4);
   endtask
   task flash(input logic [15:0] c, input logic keys);
      if (keys) begin
         {keyWrite, keyData} = {1'b1, 8'h55};
         tick(1);
         keyData = 8'hAA;
         tick(1);
      end
      {keyWrite, ctlWrite, ctlData} = {1'b0, 1'b1, c};
      tick(1);
      ctlWrite = 1'b0;
      started = flashControlReg_r[15];
      for (int k = 0; k < 300 && flashControlReg_r[15] !== 1'b0; k++)
         tick(1);
      tick(1);
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #20000;
      fails++;
      end_sim;
   end
   // ----
   // Main sequence
   // ----
   initial begin
      {tblReq, tblWrite, tblHigh, tblByte, dataReq, moveInstr, inRepeat, repFirst, repLast, repIrqEdge,
         keyWrite, ctlWrite, tablePageReg, windowPageReg, keyData, tblEa, tblWrData, dataEa,
         coreControlReg, ctlData} = '0;
      reset = 1'b1;
      tick(2);
      reset = 1'b0;
      chk("control reset", flashControlReg_r, 0);
      foreach (rows[i]) begin
         tbl(0, rows[i].hi, rows[i].by, 8'h01, rows[i].ea, 0);
         chk("table read", rd, rows[i].ex);
      end
      tbl(0, 0, 0, 8'h80, 16'h0002, 0);
      chk("cfg read refused", refd, 0);
      tbl(0, 0, 0, 8'h80, 16'h0008, 0);
      chk("cfg outside refused", refd, 1);
      chk("cfg outside data", rd, 0);
      tbl(1, 0, 0, 8'h80, 16'h0030, 16'h1234);
      chk("cfg write refused", refd, 1);
      $display("table reads done");
      foreach (xrows[i]) begin
         win(16'h8010, 16'h0004, xrows[i][6:2]);
         chk("window hit", hits - n0, 1);
         chk("extra cycles", xcv, xrows[i][1:0]);
         chk("window data", windowData_r, 16'hCB9E);
      end
      win(16'h0010, 16'h0004, 0);
      chk("low address hit", hits - n0, 0);
      win(16'h8010, 16'h0000, 0);
      chk("disabled hit", hits - n0, 0);
      {dataEa, coreControlReg, dataReq} = {16'h8010, 16'h0004, 1'b1};
      n0 = hits;
      tbl(0, 0, 0, 8'h00, 16'h0010, 0);
      chk("hit during table", hits - n0, 0);
      $display("window done");
      // Fewer than a full row of latch writes; no location is programmed twice
      tbl(1, 0, 0, 8'h00, 16'h0020, 16'h1111);
      tbl(1, 0, 0, 8'h00, 16'h0020, 16'h2222);
      tbl(1, 1, 0, 8'h00, 16'h0020, 16'h0077);
      tbl(0, 0, 0, 8'h00, 16'h0020, 0);
      chk("before program", rd, 16'hD386);
      n0 = progs;
      flash(16'hC018, 1);
      chk("program start", started, 1);
      chk("programmed words", progs - n0, 1);
      tbl(0, 0, 0, 8'h00, 16'h0020, 0);
      chk("low programmed", rd, 16'h2222);
      tbl(0, 1, 0, 8'h00, 16'h0020, 0);
      chk("high programmed", rd, 16'h0077);
      tbl(0, 0, 0, 8'h00, 16'h0022, 0);
      chk("neighbour word", rd, 16'hD287);
      for (int j = 0; j < 3; j++) begin
         tbl(1, 0, 0, 8'h00, 16'h0046, 0);
         n0 = erases;
         flash(16'hC058 | j, 1);
         chk("erase pulses", erases - n0, 1);
         chk("erase base", eraseAddr[7:0], (j == 0) ? 8'h40 : 8'h00);
      end
      tbl(0, 0, 0, 8'h00, 16'h0046, 0);
      chk("erased word", rd, 16'hFFFF);
      flash(16'hC018, 0);
      chk("start without keys", started, 0);
      $display("flash done");
      end_sim;
   end
endmodule // tb_pmta_access_unit
`default_nettype wire
